// [hdl/fsu_ctrl.sv]
// dual-role full-speed port controller: roles, port, frames, scheduler
// Behaviour
// - 48 MHz USB ticks made from the 250 MHz bus clock
// - force bits select host or device role
// - OTG: bits clear, ID picks role
// - host role assumes bus power present
// - ignore bit with device role forced: power on, pull-up on
// - VBUS lost drops DP pull-up one cycle later
// - port: off, disconnected, connected, enabled
// - connect and disconnect flags in host
// - reset bit honoured when connected or enabled
// - speed from which line is pulled up
// - suspend bit stops SOF when enabled
// - resume bit drives resume signalling
// - remote wakeup sets flag and interrupt
// - enabled port sends SOF every frame
// - frame interval writable, remaining frozen suspended
// - 16-cycle SOF pulse when enabled
// - eight channels with type, direction, length
// - periodic and non-periodic request queues
// - full OUT packet queues request itself
// - periodic queue first after frame start
// - disable entry acts at once, next
// - no time: periodic skips, non-periodic halts
// - device powered by VBUS or ignore bit
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module fsu_ctrl #(
    parameter int NUM_CH = fsu_pkg::NUM_CHANNELS,
    parameter int QD     = fsu_pkg::QUEUE_DEPTH
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             sof_pulse,
    output logic             wakeup_irq,
    fsu_link_if.ctl          link
);
    import fsu_pkg::*;
    localparam int QW = $clog2(QD);

    function automatic logic is_periodic(input logic [1:0] ttype);
        is_periodic = ttype[0];  // types 1 iso and 3 interrupt
    endfunction
    function automatic logic [16:0] need_ticks(input logic [10:0] len);
        need_ticks = 17'((len + 11'(OVH_BYTES)) * BYTE_TICKS);
    endfunction

    // bus slave: zero wait, read data captured in the address phase
    logic [31:0] hrdata_q, rd_val;
    logic [7:0]  wa_q;
    logic        we_q, hready_q;
    wire         aphase = hsel & htrans[1] & hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0;
            wa_q     <= 8'h0;
            we_q     <= 1'b0;
            hready_q <= 1'b0;
        end else begin
            hready_q <= 1'b1;
            we_q     <= aphase & hwrite;
            if (aphase) begin
                wa_q     <= haddr[7:0];
                hrdata_q <= hwrite ? 32'h0 : rd_val;
            end
        end
    end
    assign hrdata    = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp     = 1'b0;

    wire       wr_cfg  = we_q & (wa_q == A_CFG);
    wire       wr_port = we_q & (wa_q == A_PORT);
    wire       wr_frm  = we_q & (wa_q == A_FRAME);
    wire       wr_ch   = we_q & (wa_q[7:5] == A_CH_BLK);
    wire       wr_fifo = we_q & (wa_q[7:5] == A_FIFO_BLK);
    wire [2:0] wch     = wa_q[4:2];

    // registers
    logic force_host_role_bit_q, force_device_role_bit_q;
    logic bus_power_ignore_bit_q, sof_pulse_output_enable_q;
    logic port_power_bit_q, port_reset_bit_q, port_suspend_bit_q, port_resume_bit_q;
    logic conn_flag_q, disc_flag_q, wakeup_interrupt_flag_q, rst_act_q;
    logic [1:0]  port_speed_field_q;
    logic [15:0] frame_interval_field_q, frame_remaining_field_q;
    logic [10:0] frame_num_q;
    logic [13:0] ch_cfg_q [NUM_CH];
    logic [9:0]  ch_words_q [NUM_CH];
    logic [NUM_CH-1:0] ch_en_q;
    logic [7:0]  tick_acc_q;
    logic [4:0]  sof_cnt_q;
    logic [16:0] busy_q;
    logic        sof_q, wake_irq_q, pu_q, tok_v_q, tok_sof_q, tok_in_q, ret_per_q;
    logic [2:0]  tok_ch_q;
    logic [10:0] tok_data_q;
    fsu_port_t   port_q, port_d;
    fsu_sched_t  sched_q, sched_d;

    // usb clock tick: 48 of every 250 cycles, by fractional accumulation
    wire [8:0] acc_sum = 9'(tick_acc_q) + 9'(USB_MHZ);
    wire       tick    = acc_sum >= 9'(CLK_MHZ);

    wire otg       = ~force_host_role_bit_q & ~force_device_role_bit_q & ~bus_power_ignore_bit_q;
    // ID low means A side, host
    wire host_role = (force_host_role_bit_q & ~force_device_role_bit_q) | (otg & ~link.id);
    wire dev_role  = (force_device_role_bit_q & ~force_host_role_bit_q) | (otg & link.id);
    wire vbus_ok   = host_role | link.vbus;
    wire dev_pow   = dev_role & (bus_power_ignore_bit_q | link.vbus);

    // host port
    wire line_act  = link.dp | link.dm;
    wire conn_or_en = (port_q == P_CONN) | (port_q == P_ENA);
    wire rst_end   = rst_act_q & ~port_reset_bit_q;
    wire resume_on = port_resume_bit_q & (port_q == P_ENA);
    wire susp_act  = port_suspend_bit_q & (port_q == P_ENA);
    wire running   = (port_q == P_ENA) & ~rst_act_q & ~port_suspend_bit_q;
    wire line_k    = (port_speed_field_q == SPD_FULL) ? (link.dm & ~link.dp)
                                                      : (link.dp & ~link.dm);
    always_comb begin
        port_d = port_q;
        case (port_q)
            P_OFF:   if (port_power_bit_q) port_d = P_DISC;
            P_DISC:  if (line_act) port_d = P_CONN;
            P_CONN:  if (rst_end) port_d = P_ENA;
            P_ENA:   port_d = P_ENA;
            default: port_d = P_OFF;
        endcase
        if (!host_role || !port_power_bit_q || !vbus_ok)
            port_d = P_OFF;
        else if (conn_or_en && !line_act && !rst_act_q && !resume_on)
            port_d = P_DISC;
    end
    wire conn_ev = (port_q == P_DISC) & (port_d == P_CONN);
    wire disc_ev = conn_or_en & (port_d == P_DISC);
    wire wake_ev = susp_act & ~resume_on & line_k;

    // frames
    // frame starts when a reset ends on an enabled port and at each wrap
    wire frame_start = ((port_q == P_ENA) & rst_end) | (running & tick & (frame_remaining_field_q == 16'h0));
    wire [4:0] sof_cnt_d = (frame_start & sof_pulse_output_enable_q) ? SOF_PULSE_CYC
                         : ((sof_cnt_q != 5'h0) ? sof_cnt_q - 5'h1 : 5'h0);

    // request queues: index 1 periodic, 0 non-periodic; entry {disable, channel}
    logic [3:0]    qmem [2][QD];
    logic [QW-1:0] wp_q [2];
    logic [QW-1:0] rp_q [2];
    logic [QW:0]   qc_q [2];
    logic [1:0]    push, pop;
    wire           fifo_done  = wr_fifo & ~ch_cfg_q[wch][11]
                              & ((ch_words_q[wch] + 10'h1) >= 10'((ch_cfg_q[wch][10:0] + 11'h3) >> 2));
    wire           push_dis   = wr_ch & hwdata[CH_DIS];
    wire           push_any   = push_dis | (wr_ch & hwdata[CH_GO]) | fifo_done;
    wire [1:0]     push_type  = wr_ch ? hwdata[13:12] : ch_cfg_q[wch][13:12];
    assign push = {push_any & is_periodic(push_type), push_any & ~is_periodic(push_type)};

    for (genvar g = 0; g < 2; g++) begin : g_queue
        wire full = qc_q[g] == (QW+1)'(QD);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                wp_q[g] <= '0;
                rp_q[g] <= '0;
                qc_q[g] <= '0;
            end else begin
                if (push[g] & ~full)
                    wp_q[g] <= wp_q[g] + QW'(1);
                if (pop[g])
                    rp_q[g] <= rp_q[g] + QW'(1);
                qc_q[g] <= qc_q[g] + (QW+1)'(push[g] & ~full) - (QW+1)'(pop[g]);
            end
        end
        always_ff @(posedge hclk) begin
            if (push[g] & ~full)
                qmem[g][wp_q[g]] <= {push_dis, wch};
        end
    end

    // scheduler
    wire        cur_per  = sched_q == S_PER;
    wire [3:0]  hd       = cur_per ? qmem[1][rp_q[1]] : qmem[0][rp_q[0]];
    wire        hd_empty = cur_per ? (qc_q[1] == '0) : (qc_q[0] == '0);
    wire        fits     = need_ticks(ch_cfg_q[hd[2:0]][10:0]) <= 17'(frame_remaining_field_q);
    // one idle cycle after any token keeps tokens apart on the line
    wire        serving  = (cur_per | (sched_q == S_NP)) & ~hd_empty & ~frame_start & ~tok_v_q;
    wire        dis_pop  = serving & hd[3];
    wire        issue    = serving & ~hd[3] & fits;
    assign pop = {(dis_pop | issue) & cur_per, (dis_pop | issue) & ~cur_per};
    always_comb begin
        sched_d = sched_q;
        case (sched_q)
            S_IDLE:  if (frame_start) sched_d = S_PER;
            S_PER:   if (issue) sched_d = S_BUSY;
                     else if (!frame_start && (hd_empty || (!hd[3] && !fits))) sched_d = S_NP;
            S_NP:    if (frame_start) sched_d = S_PER;
                     else if (issue) sched_d = S_BUSY;
                     else if (!hd_empty && !hd[3] && !fits) sched_d = S_HALT;
            S_BUSY:  if (busy_q == 17'h0) sched_d = ret_per_q ? S_PER : S_NP;
            S_HALT:  if (frame_start) sched_d = S_PER;
            default: sched_d = S_IDLE;
        endcase
        if (!running)
            sched_d = S_IDLE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            force_host_role_bit_q     <= 1'b0;
            force_device_role_bit_q   <= 1'b0;
            bus_power_ignore_bit_q    <= 1'b0;
            sof_pulse_output_enable_q <= 1'b0;
            {port_resume_bit_q, port_suspend_bit_q, port_reset_bit_q, port_power_bit_q} <= 4'h0;
            conn_flag_q <= 1'b0;
            disc_flag_q <= 1'b0;
            wakeup_interrupt_flag_q <= 1'b0;
            rst_act_q   <= 1'b0;
            port_speed_field_q      <= 2'h0;
            frame_interval_field_q  <= FRI_RST;
            frame_remaining_field_q <= 16'h0;
            frame_num_q <= 11'h0;
            ch_en_q     <= '0;
            tick_acc_q  <= 8'h0;
            sof_cnt_q   <= 5'h0;
            sof_q       <= 1'b0;
            wake_irq_q  <= 1'b0;
            pu_q        <= 1'b0;
            busy_q      <= 17'h0;
            ret_per_q   <= 1'b0;
            tok_v_q     <= 1'b0;
            tok_sof_q   <= 1'b0;
            tok_in_q    <= 1'b0;
            tok_ch_q    <= 3'h0;
            tok_data_q  <= 11'h0;
            port_q      <= P_OFF;
            sched_q     <= S_IDLE;
            for (int c = 0; c < NUM_CH; c++) begin
                ch_cfg_q[c]   <= 14'h0;
                ch_words_q[c] <= 10'h0;
            end
        end else begin
            tick_acc_q <= tick ? 8'(acc_sum - 9'(CLK_MHZ)) : acc_sum[7:0];
            if (wr_cfg)
                {sof_pulse_output_enable_q, bus_power_ignore_bit_q,
                 force_device_role_bit_q, force_host_role_bit_q} <= hwdata[3:0];
            if (wr_port)
                {port_resume_bit_q, port_suspend_bit_q, port_reset_bit_q, port_power_bit_q}
                    <= hwdata[3:0];
            if (wr_frm)
                frame_interval_field_q <= hwdata[15:0];
            port_q  <= port_d;
            sched_q <= sched_d;
            // reset only when connected or enabled
            rst_act_q <= port_reset_bit_q & conn_or_en & (port_d != P_DISC);
            if (conn_ev)
                port_speed_field_q <= link.dp ? SPD_FULL : SPD_LOW;
            // set wins over write-one-to-clear
            conn_flag_q <= conn_ev | (conn_flag_q & ~(wr_port & hwdata[PT_CONN]));
            disc_flag_q <= disc_ev | (disc_flag_q & ~(wr_port & hwdata[PT_DISC]));
            wakeup_interrupt_flag_q <= wake_ev
                | (wakeup_interrupt_flag_q & ~(wr_port & hwdata[PT_WAKE]));
            wake_irq_q <= wake_ev | (wakeup_interrupt_flag_q & ~(wr_port & hwdata[PT_WAKE]));
            if (frame_start) begin
                frame_remaining_field_q <= frame_interval_field_q - 16'h1;
                frame_num_q <= frame_num_q + 11'h1;
            end else if (running & tick)
                frame_remaining_field_q <= frame_remaining_field_q - 16'h1;
            sof_cnt_q <= sof_cnt_d;
            sof_q     <= sof_cnt_d != 5'h0;
            pu_q      <= dev_pow;
            // SOF token, transaction handed to the line engine
            tok_v_q   <= frame_start | issue;
            tok_sof_q <= frame_start;
            if (frame_start)
                tok_data_q <= frame_num_q;
            else if (issue) begin
                tok_ch_q   <= hd[2:0];
                tok_in_q   <= ch_cfg_q[hd[2:0]][11];
                tok_data_q <= ch_cfg_q[hd[2:0]][10:0];
            end
            if (issue) begin
                busy_q    <= need_ticks(ch_cfg_q[hd[2:0]][10:0]);
                ret_per_q <= cur_per;
            end else if (tick & (busy_q != 17'h0))
                busy_q <= busy_q - 17'h1;
            if (frame_start & (sched_q == S_BUSY))
                ret_per_q <= 1'b1;
            for (int c = 0; c < NUM_CH; c++) begin
                if (wr_ch & (wch == 3'(c)))
                    ch_cfg_q[c] <= hwdata[13:0];
                if (wr_fifo & (wch == 3'(c)))
                    ch_words_q[c] <= fifo_done ? 10'h0 : ch_words_q[c] + 10'h1;
                if (push_any & ~push_dis & (wch == 3'(c)))
                    ch_en_q[c] <= 1'b1;
                else if (dis_pop & (hd[2:0] == 3'(c)))
                    ch_en_q[c] <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_val = 32'h0;
        case (haddr[7:0])
            A_CFG:   rd_val = {28'h0, sof_pulse_output_enable_q, bus_power_ignore_bit_q,
                               force_device_role_bit_q, force_host_role_bit_q};
            A_PORT:  rd_val = {18'h0, rst_act_q, wakeup_interrupt_flag_q, disc_flag_q,
                               conn_flag_q, port_speed_field_q, port_q, port_resume_bit_q,
                               port_suspend_bit_q, port_reset_bit_q, port_power_bit_q};
            A_FRAME: rd_val = {frame_remaining_field_q, frame_interval_field_q};
            A_STAT:  rd_val = {19'h0, sched_q, 4'h0, pu_q, dev_pow, dev_role, host_role};
            default: if (haddr[7:5] == A_CH_BLK)
                         rd_val = {17'h0, ch_en_q[haddr[4:2]], ch_cfg_q[haddr[4:2]]};
        endcase
    end

    // SE0 during reset, K during resume
    assign link.c_dp_oe  = rst_act_q | resume_on;
    assign link.c_dm_oe  = rst_act_q | resume_on;
    assign link.c_dp_o   = resume_on & (port_speed_field_q == SPD_LOW);
    assign link.c_dm_o   = resume_on & (port_speed_field_q == SPD_FULL);
    assign link.c_dp_pu  = pu_q;
    assign link.tok_valid = tok_v_q;
    assign link.tok_sof  = tok_sof_q;
    assign link.tok_in   = tok_in_q;
    assign link.tok_ch   = tok_ch_q;
    assign link.tok_data = tok_data_q;
    assign sof_pulse     = sof_q;
    assign wakeup_irq    = wake_irq_q;
endmodule // fsu_ctrl
`default_nettype wire

// [hdl/fsu_far.sv]
// far party: remote full-speed or low-speed device model in logic
`timescale 1ns/10ps
`default_nettype none
module fsu_far #(
    parameter int SUSP_CYC = fsu_pkg::SUSP_CYC,
    parameter int WAKE_CYC = fsu_pkg::WAKE_CYC
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    fsu_link_if.far         link,
    input  wire logic       attach,
    input  wire logic       full_speed,
    input  wire logic       vbus_on,
    input  wire logic       id_level,
    input  wire logic       wake_req,
    output logic            suspended,
    output logic            bus_reset,
    output logic            sof_seen,
    output logic            trans_seen,
    output logic [2:0]      trans_ch
);
    import fsu_pkg::*;
    localparam int SW = $clog2(SUSP_CYC + 1);
    localparam int WW = $clog2(WAKE_CYC + 1);
    logic          dp_pu_q, dm_pu_q, vbus_q, id_q, susp_q, rst_q, sof_q, tr_q, fs_q;
    logic [2:0]    ch_q;
    logic [SW-1:0] idle_q;
    logic [WW-1:0] wake_q;
    wire se0    = link.c_dp_oe & link.c_dm_oe & ~link.dp & ~link.dm;
    wire host_k = link.c_dm_oe & (fs_q ? (link.dm & ~link.dp) : (link.dp & ~link.dm));
    wire waking = wake_q != '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_pu_q <= 1'b0;
            dm_pu_q <= 1'b0;
            vbus_q  <= 1'b0;
            id_q    <= 1'b1;
            fs_q    <= 1'b1;
            susp_q  <= 1'b0;
            rst_q   <= 1'b0;
            sof_q   <= 1'b0;
            tr_q    <= 1'b0;
            ch_q    <= 3'h0;
            idle_q  <= '0;
            wake_q  <= '0;
        end else begin
            dp_pu_q <= attach & full_speed;
            dm_pu_q <= attach & ~full_speed;
            fs_q    <= full_speed;
            vbus_q  <= vbus_on;
            id_q    <= id_level;
            rst_q   <= se0;
            sof_q   <= link.tok_valid & link.tok_sof;
            tr_q    <= link.tok_valid & ~link.tok_sof;
            if (link.tok_valid & ~link.tok_sof)
                ch_q <= link.tok_ch;
            if (link.tok_valid | se0 | host_k | ~attach)
                idle_q <= '0;
            else if (idle_q != SW'(SUSP_CYC))
                idle_q <= idle_q + SW'(1);
            if (se0 | host_k | ~attach | (wake_q == WW'(1)))
                susp_q <= 1'b0;
            else if (idle_q == SW'(SUSP_CYC - 1))
                susp_q <= 1'b1;
            if (wake_req & susp_q & ~waking)
                wake_q <= WW'(WAKE_CYC);
            else if (waking)
                wake_q <= wake_q - WW'(1);
        end
    end
    // K state: dm high for full speed, dp high for low speed
    assign link.f_dp_oe = waking;
    assign link.f_dm_oe = waking;
    assign link.f_dp_o  = ~fs_q;
    assign link.f_dm_o  = fs_q;
    assign link.f_dp_pu = dp_pu_q;
    assign link.f_dm_pu = dm_pu_q;
    assign link.vbus    = vbus_q;
    assign link.id      = id_q;
    assign suspended    = susp_q;
    assign bus_reset    = rst_q;
    assign sof_seen     = sof_q;
    assign trans_seen   = tr_q;
    assign trans_ch     = ch_q;
endmodule // fsu_far
`default_nettype wire

// [hdl/fsu_link_if.sv]
// link between the controller and the far party: line pins, power, tokens
`timescale 1ns/10ps
`default_nettype none
interface fsu_link_if;
    logic        c_dp_o, c_dp_oe, c_dm_o, c_dm_oe, c_dp_pu;
    logic        tok_valid, tok_sof, tok_in;
    logic [2:0]  tok_ch;
    logic [10:0] tok_data;
    logic        f_dp_o, f_dp_oe, f_dm_o, f_dm_oe, f_dp_pu, f_dm_pu, vbus, id;
    logic        dp, dm;
    // undriven lines fall to the pull-downs unless a pull-up is on
    assign dp = c_dp_oe ? c_dp_o : (f_dp_oe ? f_dp_o : (c_dp_pu | f_dp_pu));
    assign dm = c_dm_oe ? c_dm_o : (f_dm_oe ? f_dm_o : f_dm_pu);
    modport ctl (output c_dp_o, c_dp_oe, c_dm_o, c_dm_oe, c_dp_pu,
                 output tok_valid, tok_sof, tok_in, tok_ch, tok_data,
                 input dp, dm, vbus, id);
    modport far (output f_dp_o, f_dp_oe, f_dm_o, f_dm_oe, f_dp_pu, f_dm_pu, vbus, id,
                 input c_dp_oe, c_dm_oe, tok_valid, tok_sof, tok_in, tok_ch, tok_data,
                 input dp, dm);
endinterface // fsu_link_if
`default_nettype wire

// [hdl/fsu_pkg.sv]
// shared constants and types for the full-speed dual-role port controller
package fsu_pkg;
    localparam int CLK_MHZ      = 250;
    localparam int USB_MHZ      = 48;
    localparam int NUM_CHANNELS = 8;
    localparam int QUEUE_DEPTH  = 4;
    // register byte offsets
    localparam logic [7:0] A_CFG   = 8'h00;
    localparam logic [7:0] A_PORT  = 8'h04;
    localparam logic [7:0] A_FRAME = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0C;
    localparam logic [2:0] A_CH_BLK   = 3'h1;
    localparam logic [2:0] A_FIFO_BLK = 3'h2;
    // field positions
    localparam int CFG_FHOST = 0;
    localparam int CFG_FDEV  = 1;
    localparam int CFG_VIGN  = 2;
    localparam int CFG_SOFOE = 3;
    localparam int PT_PWR    = 0;
    localparam int PT_RST    = 1;
    localparam int PT_SUSP   = 2;
    localparam int PT_RES    = 3;
    localparam int PT_CONN   = 10;
    localparam int PT_DISC   = 11;
    localparam int PT_WAKE   = 12;
    localparam int CH_GO     = 16;
    localparam int CH_DIS    = 17;
    // reset values and timing
    localparam logic [15:0] FRI_RST      = 16'hBB80;
    localparam logic [4:0]  SOF_PULSE_CYC = 5'h10;
    localparam logic [1:0]  SPD_FULL     = 2'h1;
    localparam logic [1:0]  SPD_LOW      = 2'h2;
    localparam int BYTE_TICKS   = 32;
    localparam int OVH_BYTES    = 8;
    localparam int SUSP_TIME_US = 3000;
    localparam int SUSP_CYC     = SUSP_TIME_US * CLK_MHZ;
    localparam int WAKE_TIME_US = 1000;
    localparam int WAKE_CYC     = WAKE_TIME_US * CLK_MHZ;
    typedef enum logic [3:0] {
        P_OFF  = 4'h1,
        P_DISC = 4'h2,
        P_CONN = 4'h4,
        P_ENA  = 4'h8
    } fsu_port_t;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_PER  = 5'h02,
        S_NP   = 5'h04,
        S_BUSY = 5'h08,
        S_HALT = 5'h10
    } fsu_sched_t;
endpackage

// [verification/fsu_chk.sv]
// link-side timing checks between the two ends of the port controller
`timescale 1ns/10ps
`default_nettype none
module fsu_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        c_dp_o,
    input wire logic        c_dp_oe,
    input wire logic        c_dm_o,
    input wire logic        c_dm_oe,
    input wire logic        c_dp_pu,
    input wire logic        tok_valid,
    input wire logic        tok_sof,
    input wire logic [10:0] tok_data,
    input wire logic        sof_pulse
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire se0 = c_dp_oe && c_dm_oe && !c_dp_o && !c_dm_o;
    a_tok_one_cycle: assert property (tok_valid |=> !tok_valid)
        else $error("token strobe longer than one cycle");
    a_tok_data_stands: assert property (!tok_valid |-> $stable(tok_data))
        else $error("token data moved without a token");
    // no frame traffic may start while the bus is held in reset
    a_reset_quiet: assert property (se0 [*2] |-> !tok_valid)
        else $error("token sent during bus reset");
    a_pullup_no_drive: assert property (c_dp_pu |-> !c_dp_oe && !c_dm_oe)
        else $error("line driven while device pull-up is on");
    a_sof_pulse_len: assert property ($rose(sof_pulse) |-> sof_pulse [*8] ##1 sof_pulse [*8] ##1 !sof_pulse)
        else $error("SOF pulse not sixteen cycles long");
    a_pulse_with_sof: assert property ($rose(sof_pulse) |-> tok_valid && tok_sof)
        else $error("SOF pulse without an SOF token");
endmodule // fsu_chk
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench: controller and far party joined by the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t mismatch", $time); end end
module testbench;
    import fsu_pkg::*;
    logic        hclk = 0, hresetn = 0, hwrite = 0, attach = 0, vbus_on = 0, wake_req = 0;
    logic        full_speed = 1, id_level = 0, sof_seen;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv, keep;
    logic        hready, sof_pulse, wakeup_irq, suspended, bus_reset, trans_seen;
    logic [2:0]  trans_ch;
    int          n_fail = 0, n_tests = 0, i, n, cyc = 0;
    fsu_link_if lk();
    fsu_ctrl i_fsu_ctrl (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(), .sof_pulse, .wakeup_irq, .link(lk));
    // idle limit above one frame so the far end only suspends once SOFs stop
    fsu_far #(.SUSP_CYC(4000), .WAKE_CYC(20)) i_fsu_far (.hclk, .hresetn, .link(lk), .attach,
        .full_speed, .vbus_on, .id_level, .wake_req, .suspended, .bus_reset,
        .sof_seen, .trans_seen, .trans_ch);
    fsu_chk i_fsu_chk (.hclk, .hresetn, .c_dp_o(lk.c_dp_o), .c_dp_oe(lk.c_dp_oe),
        .c_dm_o(lk.c_dm_o), .c_dm_oe(lk.c_dm_oe), .c_dp_pu(lk.c_dp_pu),
        .tok_valid(lk.tok_valid), .tok_sof(lk.tok_sof), .tok_data(lk.tok_data), .sof_pulse);
    always #2 hclk = ~hclk;
    // a hung wait must still reach the verdict
    always @(posedge hclk) if (++cyc == 60000) begin n_fail++; $display("ERROR %0t timeout", $time); results; end
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rv = hrdata;
    endtask
    task t_dev;
        bus(1, A_CFG, 32'h2); vbus_on <= 1'b1;
        // vbus and the pull-up each pass one register stage
        repeat (2) @(posedge hclk);
        bus(0, A_STAT, 0); `CHK(rv[3:0], 4'hE)
        vbus_on <= 1'b0;
        repeat (2) @(posedge hclk);
        bus(0, A_STAT, 0); `CHK(rv[3], 1'b0)
        bus(1, A_CFG, 32'h6); bus(0, A_STAT, 0); `CHK(rv[3:0], 4'hE)
        bus(1, A_CFG, 32'h0); bus(0, A_STAT, 0); `CHK(rv[1:0], 2'h1)
        id_level <= 1'b1;
        bus(0, A_STAT, 0); `CHK(rv[1:0], 2'h2)
        bus(0, 8'hF0, 0); `CHK(rv, 32'h0)
        $display("device role test done");
    endtask
    task t_host;
        bus(1, A_CFG, 32'h9); bus(0, A_PORT, 0); `CHK(rv[7:4], 4'h1)
        bus(0, A_FRAME, 0); `CHK(rv[15:0], FRI_RST)
        bus(1, A_FRAME, 32'h200); bus(1, A_PORT, 32'h1); attach <= 1'b1;
        bus(0, A_PORT, 0); bus(0, A_PORT, 0); `CHK(rv[10:4], 7'h54)
        bus(1, A_PORT, 32'h3); bus(0, A_PORT, 0); `CHK(bus_reset, 1'b1)
        bus(1, A_PORT, 32'h1); bus(0, A_PORT, 0); `CHK(rv[7:4], 4'h8)
        // a pulse already under way would be counted short
        for (i = 0; i < 40 && sof_pulse !== 1'b0; i++) @(negedge hclk);
        for (i = 0; i < 9000 && sof_pulse !== 1'b1; i++) @(negedge hclk);
        @(negedge hclk);
        `CHK(sof_seen, 1'b1)
        for (n = 1; n < 40 && sof_pulse === 1'b1; n++) @(negedge hclk);
        `CHK(n, 16)
        // four bytes fill the packet, so one word queues the entry
        bus(1, 8'h2C, 32'h2004); bus(1, 8'h4C, 32'hA5A5A5A5);
        for (i = 0; i < 9000 && trans_seen !== 1'b1; i++) @(negedge hclk);
        `CHK(trans_ch, 3'h3)
        bus(1, 8'h2C, 32'h22004); bus(0, 8'h2C, 0); `CHK(rv[14], 1'b1)
        // the disable entry waits behind the transaction that holds the bus
        for (i = 0; i < 3000 && rv[14] !== 1'b0; i++) bus(0, 8'h2C, 0);
        `CHK(rv[14], 1'b0)
        `CHK(suspended, 1'b0)
        bus(1, A_PORT, 32'h5); bus(0, A_FRAME, 0); keep = rv;
        for (i = 0; i < 9000 && suspended !== 1'b1; i++) @(negedge hclk);
        `CHK(suspended, 1'b1)
        bus(0, A_FRAME, 0); `CHK(rv[31:16], keep[31:16])
        wake_req <= 1'b1;
        for (i = 0; i < 9000 && wakeup_irq !== 1'b1; i++) @(negedge hclk);
        `CHK(wakeup_irq, 1'b1)
        bus(1, A_PORT, 32'h1001); wake_req <= 1'b0; attach <= 1'b0;
        // the far end's wakeup K keeps the line busy for a while after detach
        for (i = 0; i < 50 && rv[11] !== 1'b1; i++) bus(0, A_PORT, 0);
        `CHK(rv[11], 1'b1)
        `CHK(rv[7:4], 4'h2)
        full_speed <= 1'b0; attach <= 1'b1;
        bus(0, A_PORT, 0); bus(0, A_PORT, 0); `CHK(rv[9:8], SPD_LOW)
        $display("host role test done");
    endtask
    task results;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_dev;
        t_host;
        results;
    end
endmodule // testbench
`default_nettype wire
